// >>> design/hub_pkg.sv
// Shared constants and carrier types for the sensor hub FIFO command decoder
package hub_pkg;
  localparam int SMP_W = 48;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [2:0] SMP_LAST = 3'h5;
  localparam logic [2:0] WCNT_SAT = 3'h4;
  localparam logic [7:0] FAM_OUT_FIFO = 8'h12;
  localparam logic [7:0] FAM_IN_INFO = 8'h13;
  localparam logic [7:0] FAM_IN_WRITE = 8'h14;
  localparam logic [7:0] FAM_REG_WR = 8'h40;
  localparam logic [7:0] FAM_REG_RD = 8'h41;
  localparam logic [7:0] IDX_OUT_COUNT = 8'h00;
  localparam logic [7:0] IDX_OUT_DATA = 8'h01;
  localparam logic [7:0] IDX_SMP_SIZE = 8'h00;
  localparam logic [7:0] IDX_IN_CAP = 8'h01;
  localparam logic [7:0] IDX_SNS_CAP = 8'h02;
  localparam logic [7:0] IDX_IN_OCC = 8'h03;
  localparam logic [7:0] IDX_SNS_OCC = 8'h04;
  localparam logic [7:0] IDX_IN_WRITE = 8'h00;
  localparam logic [7:0] SEL_ACCEL = 8'h04;
  localparam logic [7:0] ACCEL_SMP_BYTES = 8'h06;
  localparam logic [15:0] IN_FIFO_CAP = 16'h0010;
  localparam logic [15:0] SNS_FIFO_CAP = 16'h0020;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BUSY = 8'hFE;

  typedef enum logic [0:0] {P_IDLE, P_WAIT} phase_e;

  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
    logic stop;
  } host_wr_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sreg_req_s;

  typedef struct packed {
    phase_e phase;
    logic [2:0] wcnt;
    logic [7:0] fam;
    logic [7:0] idx;
    logic [7:0] arg0;
    logic [7:0] arg1;
    logic [7:0] status;
    logic [7:0] resp1;
    logic [7:0] resp2;
    logic [1:0] rlen;
    logic [1:0] rpos;
    logic stream;
    logic [2:0] boff;
    logic [PTR_W-1:0] out_head;
    logic [PTR_W-1:0] out_tail;
    logic [CNT_W-1:0] out_cnt;
    logic out_stale;
    logic [PTR_W-1:0] in_head;
    logic [PTR_W-1:0] in_tail;
    logic [CNT_W-1:0] in_cnt;
    logic in_stale;
    logic [39:0] asm_buf;
    logic [2:0] asm_cnt;
    logic [7:0] rd_data;
    logic rd_valid;
    sreg_req_s sreg;
    logic flag;
  } state_s;

  localparam state_s STATE_RST = '0;
endpackage

// >>> design/sample_mem.sv
// Small sample memory with registered read data
`timescale 1ns/1ps
module sample_mem #(
  parameter int W = 48,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk, // System clock
  input wire logic wen, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [W-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [W-1:0] rdata // Registered read data
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (wen) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> design/sensor_hub_fifo_cmd_decoder.sv
// Sensor hub command decoder for output, input and sensor FIFOs and register pass-through
// Overview of operation
// - 0x12/0x00 returns output FIFO sample count
// - 0x12/0x01 streams samples, pop after six bytes
// - 0x13/0x00 with selector 0x04 returns 0x06
// - Sample is three signed 16-bit axis values
// - 0x13/0x01 returns input FIFO capacity, MSB first
// - 0x13/0x02 with selector 0x04 returns sensor FIFO capacity, MSB first
// - 0x14/0x00 writes samples into input FIFO
// - 0x40 writes address and value to sensor
// - 0x41 reads addressed register from chosen sensor
// - Input FIFO serves externally supplied accelerometer
// - Threshold reached sets flag and drives pin
`timescale 1ns/1ps
module sensor_hub_fifo_cmd_decoder (
  input wire logic clk, // 20 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire hub_pkg::host_wr_s host_wr, // Host write byte stream
  input wire logic host_rd_req, // Host asks next response byte
  output logic [7:0] host_rd_data, // Response byte
  output logic host_rd_valid, // Response byte valid pulse
  input wire logic out_push, // Producer pushes output sample
  input wire logic [hub_pkg::SMP_W-1:0] out_sample, // Output sample
  output logic out_ready, // Output FIFO not full
  output logic [hub_pkg::SMP_W-1:0] in_smp_data, // Input FIFO head sample
  output logic in_smp_valid, // Input FIFO head valid
  input wire logic in_smp_ready, // Consumer takes head sample
  input wire logic [15:0] sns_fifo_count, // Sensor FIFO occupancy
  output hub_pkg::sreg_req_s sreg_req, // Sensor register request
  input wire logic [7:0] sreg_rdata, // Sensor register read value
  input wire logic sreg_rvalid, // Sensor read value valid
  input wire logic [7:0] fifo_threshold, // Interrupt threshold, 0 off
  output logic data_ready_flag, // Threshold reached
  output logic multi_function_io_pin_n // Interrupt to host, low active
);
  import hub_pkg::*;

  state_s s_reg, s_next;
  logic [SMP_W-1:0] out_rdata;
  logic exec, out_pop, in_push, in_pop, out_wen;

  function automatic logic [CNT_W-1:0] cnt_step(logic [CNT_W-1:0] c, logic inc, logic dec);
    cnt_step = CNT_W'(c + CNT_W'(inc) - CNT_W'(dec));
  endfunction

  function automatic logic [7:0] byte_sel(logic [SMP_W-1:0] w, logic [2:0] n);
    byte_sel = w[SMP_W-1-8*n -: 8];
  endfunction

  // Axis values kept MSB first, X then Y then Z
  sample_mem #(.W(SMP_W), .D(FIFO_DEPTH), .AW(PTR_W)) u_out_mem (
    .clk(clk),
    .wen(out_wen),
    .waddr(s_reg.out_tail),
    .wdata(out_sample),
    .raddr(s_reg.out_head),
    .rdata(out_rdata)
  );

  sample_mem #(.W(SMP_W), .D(FIFO_DEPTH), .AW(PTR_W)) u_in_mem (
    .clk(clk),
    .wen(in_push),
    .waddr(s_reg.in_tail),
    .wdata({s_reg.asm_buf, host_wr.data}),
    .raddr(s_reg.in_head),
    .rdata(in_smp_data)
  );

  assign out_ready = s_reg.out_cnt != CNT_FULL;
  assign out_wen = out_push && out_ready;
  // Read data lags a pop, or a push into an empty FIFO, by one cycle; hide the stale word
  assign in_smp_valid = (s_reg.in_cnt != '0) && !s_reg.in_stale;
  assign in_pop = in_smp_valid && in_smp_ready;
  assign host_rd_data = s_reg.rd_data;
  assign host_rd_valid = s_reg.rd_valid;
  assign sreg_req = s_reg.sreg;
  assign data_ready_flag = s_reg.flag;
  assign multi_function_io_pin_n = !s_reg.flag;

  always_comb begin
    logic bad;
    bad = 1'b0;
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.sreg.wr = 1'b0;
    s_next.sreg.rd = 1'b0;
    out_pop = 1'b0;
    in_push = 1'b0;
    exec = host_wr.stop && (s_reg.wcnt >= 3'h2) && (s_reg.phase == P_IDLE);
    // Write phase collection
    if (host_wr.start) begin
      s_next.wcnt = '0;
      s_next.asm_cnt = '0;
    end else if (host_wr.valid) begin
      case (s_reg.wcnt)
        3'h0: s_next.fam = host_wr.data;
        3'h1: s_next.idx = host_wr.data;
        3'h2: s_next.arg0 = host_wr.data;
        3'h3: s_next.arg1 = host_wr.data;
        default: ;
      endcase
      if (s_reg.wcnt != WCNT_SAT) begin
        s_next.wcnt = s_reg.wcnt + 3'h1;
      end
      if (s_reg.fam == FAM_IN_WRITE && s_reg.idx == IDX_IN_WRITE && s_reg.wcnt >= 3'h2) begin
        if (s_reg.asm_cnt == SMP_LAST) begin
          // Full FIFO drops the sample; host should poll occupancy first
          in_push = s_reg.in_cnt != CNT_FULL;
          s_next.asm_cnt = '0;
        end else begin
          s_next.asm_buf = {s_reg.asm_buf[31:0], host_wr.data};
          s_next.asm_cnt = s_reg.asm_cnt + 3'h1;
        end
      end
    end
    // Command execution at end of write
    if (exec) begin
      s_next.stream = 1'b0;
      s_next.rpos = '0;
      s_next.rlen = 2'h1;
      s_next.status = ST_OK;
      s_next.boff = '0;
      case (s_reg.fam)
        FAM_OUT_FIFO: begin
          if (s_reg.idx == IDX_OUT_COUNT) begin
            s_next.resp1 = 8'(s_reg.out_cnt);
            s_next.rlen = 2'h2;
          end else if (s_reg.idx == IDX_OUT_DATA) begin
            s_next.stream = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
        FAM_IN_INFO: begin
          s_next.rlen = 2'h3;
          case (s_reg.idx)
            IDX_SMP_SIZE: begin
              bad = !(s_reg.wcnt >= 3'h3 && s_reg.arg0 == SEL_ACCEL);
              s_next.resp1 = ACCEL_SMP_BYTES;
              s_next.rlen = 2'h2;
            end
            IDX_IN_CAP: {s_next.resp1, s_next.resp2} = IN_FIFO_CAP;
            IDX_SNS_CAP: begin
              bad = !(s_reg.wcnt >= 3'h3 && s_reg.arg0 == SEL_ACCEL);
              {s_next.resp1, s_next.resp2} = SNS_FIFO_CAP;
            end
            IDX_IN_OCC: {s_next.resp1, s_next.resp2} = 16'(s_reg.in_cnt);
            IDX_SNS_OCC: {s_next.resp1, s_next.resp2} = sns_fifo_count;
            default: bad = 1'b1;
          endcase
        end
        FAM_IN_WRITE: bad = s_reg.idx != IDX_IN_WRITE;
        FAM_REG_WR: begin
          if (s_reg.wcnt >= WCNT_SAT) begin
            s_next.sreg = '{wr: 1'b1, rd: 1'b0, sel: s_reg.idx, addr: s_reg.arg0, wdata: s_reg.arg1};
          end else begin
            bad = 1'b1;
          end
        end
        FAM_REG_RD: begin
          if (s_reg.wcnt >= 3'h3) begin
            s_next.sreg = '{wr: 1'b0, rd: 1'b1, sel: s_reg.idx, addr: s_reg.arg0, wdata: 8'h00};
            s_next.phase = P_WAIT;
            s_next.rlen = 2'h2;
          end else begin
            bad = 1'b1;
          end
        end
        default: bad = 1'b1;
      endcase
      if (bad) begin
        s_next.status = ST_BAD_CMD;
        s_next.rlen = 2'h1;
        s_next.stream = 1'b0;
        s_next.phase = P_IDLE;
        s_next.sreg.wr = 1'b0;
        s_next.sreg.rd = 1'b0;
      end
    end
    if (s_reg.phase == P_WAIT && sreg_rvalid) begin
      s_next.resp1 = sreg_rdata;
      s_next.phase = P_IDLE;
    end
    // Read phase; first byte is the status, or ST_BUSY while a register read is pending
    if (host_rd_req) begin
      s_next.rd_valid = 1'b1;
      s_next.rd_data = 8'h00;
      if (s_reg.phase == P_WAIT) begin
        s_next.rd_data = ST_BUSY;
      end else if (s_reg.rpos == 2'h0) begin
        s_next.rd_data = s_reg.status;
        s_next.rpos = 2'h1;
      end else if (s_reg.stream) begin
        if (s_reg.out_cnt != '0 && !s_reg.out_stale) begin
          s_next.rd_data = byte_sel(out_rdata, s_reg.boff);
          if (s_reg.boff == SMP_LAST) begin
            s_next.boff = '0;
            out_pop = 1'b1;
          end else begin
            s_next.boff = s_reg.boff + 3'h1;
          end
        end
      end else if (s_reg.rpos < s_reg.rlen) begin
        s_next.rd_data = (s_reg.rpos == 2'h1) ? s_reg.resp1 : s_reg.resp2;
        s_next.rpos = s_reg.rpos + 2'h1;
      end
    end
    // FIFO bookkeeping
    if (out_wen) begin
      s_next.out_tail = PTR_W'(s_reg.out_tail + 1'b1);
    end
    if (out_pop) begin
      s_next.out_head = PTR_W'(s_reg.out_head + 1'b1);
    end
    s_next.out_cnt = cnt_step(s_reg.out_cnt, out_wen, out_pop);
    // First push lands in the head slot after its read was already taken
    s_next.out_stale = out_pop || (out_wen && s_reg.out_cnt == '0);
    if (in_push) begin
      s_next.in_tail = PTR_W'(s_reg.in_tail + 1'b1);
    end
    if (in_pop) begin
      s_next.in_head = PTR_W'(s_reg.in_head + 1'b1);
    end
    s_next.in_cnt = cnt_step(s_reg.in_cnt, in_push, in_pop);
    s_next.in_stale = in_pop || (in_push && s_reg.in_cnt == '0);
    s_next.flag = (fifo_threshold != 8'h00) && (8'(s_reg.out_cnt) >= fifo_threshold);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  a_count_resp: assert property (@(posedge clk) disable iff (sys_rst)
    exec && s_reg.fam == FAM_OUT_FIFO && s_reg.idx == IDX_OUT_COUNT
    |=> s_reg.resp1 == 8'($past(s_reg.out_cnt)) && s_reg.rlen == 2'h2)
    else $error("count response wrong");
  a_pop_after_six: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(s_reg.boff == SMP_LAST) && s_reg.stream && !$past(exec) |-> s_reg.out_stale && s_reg.boff == 3'h0)
    else $error("output pop not after six bytes");
  a_accel_size: assert property (@(posedge clk) disable iff (sys_rst)
    exec && s_reg.fam == FAM_IN_INFO && s_reg.idx == IDX_SMP_SIZE && s_reg.arg0 == SEL_ACCEL && s_reg.wcnt >= 3'h3
    |=> s_reg.resp1 == ACCEL_SMP_BYTES && s_reg.status == ST_OK)
    else $error("sample size answer wrong");
  a_in_capacity: assert property (@(posedge clk) disable iff (sys_rst)
    exec && s_reg.fam == FAM_IN_INFO && s_reg.idx == IDX_IN_CAP
    |=> {s_reg.resp1, s_reg.resp2} == IN_FIFO_CAP && s_reg.rlen == 2'h3)
    else $error("input capacity answer wrong");
  a_in_push_count: assert property (@(posedge clk) disable iff (sys_rst)
    in_push && !in_pop |=> s_reg.in_cnt == $past(s_reg.in_cnt) + 5'h01)
    else $error("input push not counted");
  a_sreg_write: assert property (@(posedge clk) disable iff (sys_rst)
    exec && s_reg.fam == FAM_REG_WR && s_reg.wcnt >= WCNT_SAT
    |=> sreg_req.wr && sreg_req.addr == $past(s_reg.arg0) ##1 !sreg_req.wr)
    else $error("register write not passed");
  a_sreg_read: assert property (@(posedge clk) disable iff (sys_rst)
    s_reg.phase == P_WAIT && sreg_rvalid |=> s_reg.resp1 == $past(sreg_rdata) && s_reg.phase == P_IDLE)
    else $error("register read value lost");
  a_in_occupancy: assert property (@(posedge clk) disable iff (sys_rst)
    exec && s_reg.fam == FAM_IN_INFO && s_reg.idx == IDX_IN_OCC
    |=> {s_reg.resp1, s_reg.resp2} == 16'($past(s_reg.in_cnt)))
    else $error("input occupancy answer wrong");
  a_flag_thresh: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_threshold != 8'h00 && 8'(s_reg.out_cnt) >= fifo_threshold && $stable(fifo_threshold)
    |=> data_ready_flag && !multi_function_io_pin_n)
    else $error("threshold flag not raised");
endmodule

// >>> verification/sensor_reg_model.sv
// Behavioural attached sensor front end answering register requests
`timescale 1ns/1ps
module sensor_reg_model (
  input wire logic clk, // System clock
  input wire hub_pkg::sreg_req_s sreg_req, // Register request
  input wire logic [7:0] lat, // Answer latency in cycles
  output logic [7:0] sreg_rdata, // Read value
  output logic sreg_rvalid // Read value valid
);
  import hub_pkg::*;
  logic [7:0] mem [logic [15:0]];
  logic [15:0] key;
  int wait_cnt = -1;
  initial begin
    sreg_rdata = 8'hA5;
    sreg_rvalid = 1'b0;
  end
  always @(posedge clk) begin
    if (sreg_req.wr)
      mem[{sreg_req.sel, sreg_req.addr}] = sreg_req.wdata;
    if (sreg_req.rd) begin
      key = {sreg_req.sel, sreg_req.addr};
      wait_cnt = lat;
      sreg_rvalid <= 1'b0;
      sreg_rdata <= ~sreg_rdata;
    end else if (wait_cnt == 0) begin
      sreg_rvalid <= 1'b1;
      sreg_rdata <= mem.exists(key) ? mem[key] : ~key[7:0];
      wait_cnt = -1;
    end else begin
      if (wait_cnt > 0)
        wait_cnt--;
      sreg_rvalid <= 1'b0;
      // Idle data toggles so a stale value never passes for an answer
      sreg_rdata <= ~sreg_rdata;
    end
  end
endmodule

// >>> verification/sensor_hub_fifo_cmd_decoder_test.sv
// Self-checking bench for the sensor hub FIFO command decoder
`timescale 1ns/1ps
module sensor_hub_fifo_cmd_decoder_test;
  import hub_pkg::*;
  typedef logic [7:0] bq_t[$];
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  host_wr_s host_wr = '0;
  logic host_rd_req = 1'b0;
  logic [7:0] host_rd_data;
  logic host_rd_valid;
  logic out_push = 1'b0;
  logic [SMP_W-1:0] out_sample = '0;
  logic out_ready;
  logic [SMP_W-1:0] in_smp_data;
  logic in_smp_valid;
  logic in_smp_ready = 1'b0;
  logic [15:0] sns_fifo_count = 16'h0000;
  sreg_req_s sreg_req;
  logic [7:0] sreg_rdata;
  logic sreg_rvalid;
  logic [7:0] fifo_threshold = 8'h03;
  logic data_ready_flag;
  logic multi_function_io_pin_n;
  logic [7:0] lat = 8'h00;
  int mismatches = 0;
  int compares = 0;
  int seed = 12477;
  int n;
  logic [SMP_W-1:0] oq[$];
  logic [SMP_W-1:0] iq[$];
  logic [SMP_W-1:0] s;
  logic [7:0] b;
  logic [7:0] a;
  bq_t c;
  bq_t d;
  bq_t z;

  sensor_hub_fifo_cmd_decoder DUT (.clk, .sys_rst, .host_wr, .host_rd_req, .host_rd_data, .host_rd_valid,
    .out_push, .out_sample, .out_ready, .in_smp_data, .in_smp_valid, .in_smp_ready, .sns_fifo_count,
    .sreg_req, .sreg_rdata, .sreg_rvalid, .fifo_threshold, .data_ready_flag, .multi_function_io_pin_n);
  sensor_reg_model sensor (.clk, .sreg_req, .lat, .sreg_rdata, .sreg_rvalid);

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [SMP_W-1:0] exp, input logic [SMP_W-1:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic bq_t bytes(input logic [SMP_W-1:0] v);
    bq_t r;
    for (int j = 0; j < 6; j++)
      r.push_back(v[47-8*j -: 8]);
    return r;
  endfunction

  // Reads are spaced two cycles apart, as the response path needs
  task automatic rd(output logic [7:0] v);
    tick;
    host_rd_req = 1'b1;
    tick;
    host_rd_req = 1'b0;
    chk("read valid", 1, host_rd_valid);
    v = host_rd_data;
  endtask

  task automatic cmd(input bq_t cb, input bq_t e);
    logic [7:0] r;
    tick;
    host_wr.start = 1'b1;
    tick;
    host_wr.start = 1'b0;
    foreach (cb[i]) begin
      host_wr.valid = 1'b1;
      host_wr.data = cb[i];
      tick;
    end
    host_wr.valid = 1'b0;
    host_wr.stop = 1'b1;
    tick;
    host_wr.stop = 1'b0;
    foreach (e[i]) begin
      rd(r);
      chk("response byte", e[i], r);
    end
  endtask

  task automatic push(input logic [SMP_W-1:0] v);
    tick;
    chk("out_ready", oq.size() < 16, out_ready);
    out_push = 1'b1;
    out_sample = v;
    if (oq.size() < 16)
      oq.push_back(v);
    tick;
    out_push = 1'b0;
  endtask

  task automatic chk_flag;
    tick;
    tick;
    chk("flag", fifo_threshold != 0 && oq.size() >= fifo_threshold, data_ready_flag);
    chk("pin", !(fifo_threshold != 0 && oq.size() >= fifo_threshold), multi_function_io_pin_n);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk_flag;
    // Seventeenth push must be refused by a full FIFO
    for (int k = 0; k < 17; k++) begin
      s = SMP_W'({$random(seed), $random(seed)});
      push(s);
      chk_flag;
    end
    cmd('{8'h12, 8'h00}, '{8'h00, 8'(oq.size())});
    d = {8'h00, bytes(oq[0]), bytes(oq[1])};
    cmd('{8'h12, 8'h01}, d);
    void'(oq.pop_front());
    void'(oq.pop_front());
    cmd('{8'h12, 8'h00}, '{8'h00, 8'(oq.size())});
    d = bytes(oq[0]);
    cmd('{8'h12, 8'h01}, '{8'h00, d[0], d[1], d[2]});
    cmd('{8'h12, 8'h00}, '{8'h00, 8'(oq.size())});
    foreach (d[k]) begin
      fifo_threshold = (k == 0) ? 8'h0F : (k == 1) ? 8'h00 : (k == 2) ? 8'h0E : 8'h01;
      chk_flag;
    end
    cmd('{8'h13, 8'h00, 8'h04}, '{8'h00, 8'h06});
    cmd('{8'h13, 8'h00, 8'h05}, '{8'h02});
    cmd('{8'h13, 8'h01}, '{8'h00, 8'h00, 8'h10});
    cmd('{8'h13, 8'h02, 8'h04}, '{8'h00, 8'h00, 8'h20});
    cmd('{8'h77, 8'h00}, '{8'h02, 8'h00});
    cmd('{8'h12, 8'h02}, '{8'h02});
    cmd('{8'h13, 8'h02}, '{8'h02});
    sns_fifo_count = 16'($random(seed));
    cmd('{8'h13, 8'h04}, '{8'h00, sns_fifo_count[15:8], sns_fifo_count[7:0]});
    c = '{8'h14, 8'h00};
    for (int k = 0; k < 3; k++) begin
      s = SMP_W'({$random(seed), $random(seed)});
      iq.push_back(s);
      c = {c, bytes(s)};
    end
    // Trailing partial sample is dropped at the next start
    c = {c, 8'h11, 8'h22};
    cmd(c, '{8'h00, 8'h00});
    cmd('{8'h13, 8'h03, 8'h04}, '{8'h00, 8'h00, 8'h03});
    foreach (iq[k]) begin
      n = 0;
      while (in_smp_valid !== 1'b1 && n < 20) begin
        tick;
        n++;
      end
      chk("head valid", 1, in_smp_valid);
      if (n >= 20)
        test_done;
      chk("head sample", iq[k], in_smp_data);
      in_smp_ready = 1'b1;
      tick;
      in_smp_ready = 1'b0;
    end
    cmd('{8'h13, 8'h03, 8'h04}, '{8'h00, 8'h00, 8'h00});
    a = 8'($random(seed));
    b = 8'($random(seed));
    cmd('{8'h40, 8'h04, a, b}, '{8'h00});
    cmd('{8'h40, 8'h04, a}, '{8'h02});
    cmd('{8'h41, 8'h04}, '{8'h02});
    lat = 8'h08;
    cmd('{8'h41, 8'h04, a}, '{8'hFE, 8'hFE});
    n = 0;
    while (sreg_rvalid !== 1'b1 && n < 30) begin
      tick;
      n++;
    end
    chk("sensor answer", 1, sreg_rvalid);
    if (n >= 30)
      test_done;
    cmd(z, z);
    rd(d[0]);
    chk("read status", 8'h00, d[0]);
    rd(d[1]);
    chk("read value", b, d[1]);
    test_done;
  end
endmodule
